// ===== hcs_pkg.sv
package hcs_pkg;

	// Register indices on the host register port
	localparam logic [7:0] HCS_ADDR_DEV_CFG    = 8'h12;
	localparam logic [7:0] HCS_ADDR_TEMP_CLR   = 8'h13;
	localparam logic [7:0] HCS_ADDR_ERR_CLR    = 8'h14;
	// Pointer target used when the default read pointer start is 00
	localparam logic [7:0] HCS_ADDR_ERR_STATUS = 8'h31;

	// Device configuration field positions
	localparam int HCS_CFG_PEC_BIT   = 7;
	localparam int HCS_CFG_PAR_BIT   = 6;
	localparam int HCS_CFG_PROTO_BIT = 5;
	localparam int HCS_CFG_DPE_BIT   = 4;
	localparam int HCS_CFG_DPS_HI    = 3;
	localparam int HCS_CFG_DPS_LO    = 2;
	localparam int HCS_CFG_BL_BIT    = 1;

	// Writable and implemented bit masks
	localparam logic [7:0] HCS_CFG_WR_MASK  = 8'h1e;
	localparam logic [7:0] HCS_TEMP_MASK    = 8'h0f;
	localparam logic [7:0] HCS_ERR_MASK     = 8'he3;

	// Reset values
	localparam logic [7:0] HCS_CFG_RESET    = 8'h00;
	localparam logic [7:0] HCS_CLR_RESET    = 8'h00;

	// Start code that selects the error status register
	localparam logic [1:0] HCS_DPS_ERR_STATUS = 2'h0;

	// Burst lengths in bytes
	localparam logic [2:0] HCS_BURST_SHORT = 3'h2;
	localparam logic [2:0] HCS_BURST_LONG  = 3'h4;

	// Settings the rest of the hub acts on
	typedef struct packed {
		logic       proto_i3c;
		logic       packet_check_on;
		logic       parity_ignore;
		logic       default_pointer_on;
		logic [7:0] default_pointer_addr;
		logic [2:0] burst_bytes;
	} hcs_cfg_t;

	// Register access from the protocol engine
	typedef struct packed {
		logic       wr_en;
		logic       rd_en;
		logic [7:0] addr;
		logic [7:0] wdata;
	} hcs_req_t;

	// Link events decoded by the protocol engine
	typedef struct packed {
		logic setaasa;
		logic rstdaa;
		logic bus_reset;
	} hcs_evt_t;

endpackage : hcs_pkg

// ===== hcs_config_clear.sv
// Function
// - Bit 7 read-only PEC enable, I3C only
// - RSTDAA or bus reset updates PEC, parity
// - Bit 6 parity disable ignores T bit
// - Bit 5 selects I2C or I3C
// - Protocol bit readable, updated only by events
// - Protocol change waits for START after STOP
// - Bit 4 enables default read pointer
// - Bits 3:2 start, 00 error status
// - Bit 1 burst: 2 or 4 bytes; 4 only with PEC on and default pointer on
// - Temperature clear bits clear temperature flags
// - Clear bits self-clear after target clears
// - Error clear bit 7: busy error
// - Error clear bit 6: protected block write
// - Error clear bit 5: protection register write
// - Error clear bits 1,0: PEC, parity
module hcs_config_clear
	import hcs_pkg::*;
(
	input  wire logic       mclk,
	input  wire logic       rst_b,
	input  wire logic       scl_pin,
	input  wire logic       sda_pin,
	input  wire hcs_req_t   req,
	input  wire hcs_evt_t   evt,
	input  wire logic       set_packet_check,
	input  wire logic       set_parity_disable,
	input  wire logic [3:0] temp_status_flags,
	input  wire logic [7:0] error_log_flags,
	output logic      [7:0] rd_data,
	output logic      [3:0] temp_clear_cmd,
	output logic      [7:0] error_clear_cmd,
	output hcs_cfg_t        cfg
);

	// Pin synchronisers; stage one feeds only stage two
	logic [1:0] scl_sync_reg;
	logic [1:0] sda_sync_reg;
	logic       scl_d_reg;
	logic       sda_d_reg;

	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			scl_sync_reg <= 2'h3;
			sda_sync_reg <= 2'h3;
			scl_d_reg    <= 1'b1;
			sda_d_reg    <= 1'b1;
		end else begin
			scl_sync_reg <= {scl_sync_reg[0], scl_pin};
			sda_sync_reg <= {sda_sync_reg[0], sda_pin};
			scl_d_reg    <= scl_sync_reg[1];
			sda_d_reg    <= sda_sync_reg[1];
		end
	end

	// START is SDA falling with SCL high; STOP is SDA rising with SCL high
	wire scl_s    = scl_sync_reg[1];
	wire sda_s    = sda_sync_reg[1];
	wire start_ev = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
	wire stop_ev  = scl_s & scl_d_reg & ~sda_d_reg & sda_s;

	// Address decode
	wire hit_cfg  = (req.addr == HCS_ADDR_DEV_CFG);
	wire hit_temp = (req.addr == HCS_ADDR_TEMP_CLR);
	wire hit_err  = (req.addr == HCS_ADDR_ERR_CLR);
	wire wr_cfg   = req.wr_en & hit_cfg;
	wire wr_temp  = req.wr_en & hit_temp;
	wire wr_err   = req.wr_en & hit_err;
	wire reset_ev = evt.rstdaa | evt.bus_reset;

	// Configuration state: visible value, staged write, live protocol
	logic [7:0] cfg_reg;
	logic [7:0] cfg_next;
	logic [7:0] stage_reg;
	logic       stage_pend_reg;
	logic       proto_live_reg;
	logic       stop_seen_reg;

	// Only bits 4:1 take ordinary writes; 7:5 stay untouched
	wire [7:0] stage_next = (req.wdata & HCS_CFG_WR_MASK);

	// Read-only bits follow link events; RW bits land only at STOP
	always_comb begin
		cfg_next = cfg_reg;
		if (stop_ev && stage_pend_reg) begin
			cfg_next = (cfg_reg & ~HCS_CFG_WR_MASK) | stage_reg;
		end
		if (set_packet_check) begin
			cfg_next[HCS_CFG_PEC_BIT] = 1'b1;
		end
		if (set_parity_disable) begin
			cfg_next[HCS_CFG_PAR_BIT] = 1'b1;
		end
		if (evt.setaasa) begin
			cfg_next[HCS_CFG_PROTO_BIT] = 1'b1;
		end
		if (reset_ev) begin
			cfg_next[HCS_CFG_PEC_BIT]   = 1'b0;
			cfg_next[HCS_CFG_PAR_BIT]   = 1'b0;
			cfg_next[HCS_CFG_PROTO_BIT] = 1'b0;
		end
		cfg_next[0] = 1'b0;
	end

	// A write mid-frame is held until the host closes the frame
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			cfg_reg        <= HCS_CFG_RESET;
			stage_reg      <= HCS_CFG_RESET;
			stage_pend_reg <= 1'b0;
		end else begin
			cfg_reg <= cfg_next;
			if (wr_cfg) begin
				stage_reg      <= stage_next;
				stage_pend_reg <= 1'b1;
			end else if (stop_ev) begin
				stage_pend_reg <= 1'b0;
			end
		end
	end

	// A STOP seen before the protocol bit moved must not release the switch
	wire proto_chg = cfg_next[HCS_CFG_PROTO_BIT] ^ cfg_reg[HCS_CFG_PROTO_BIT];

	// Protocol switch waits for a START that follows a STOP
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			proto_live_reg <= 1'b0;
			stop_seen_reg  <= 1'b0;
		end else begin
			if (proto_chg) begin
				stop_seen_reg <= 1'b0;
			end else if (stop_ev) begin
				stop_seen_reg <= 1'b1;
			end else if (start_ev) begin
				stop_seen_reg <= 1'b0;
			end
			if (start_ev && stop_seen_reg) begin
				proto_live_reg <= cfg_reg[HCS_CFG_PROTO_BIT];
			end
		end
	end

	// Clear-command registers; a new 1 wins over the self-clear
	logic [3:0] temp_clr_reg;
	logic [7:0] err_clr_reg;

	// Drop a bit once its target flag reads back as cleared
	wire [3:0] temp_keep = temp_clr_reg & temp_status_flags;
	wire [7:0] err_keep  = err_clr_reg & error_log_flags & HCS_ERR_MASK;
	// Writing 0 sets nothing; reserved bits never stored
	wire [3:0] temp_set  = wr_temp ? (req.wdata[3:0] & HCS_TEMP_MASK[3:0]) : 4'h0;
	wire [7:0] err_set   = wr_err ? (req.wdata & HCS_ERR_MASK) : 8'h00;

	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			temp_clr_reg <= HCS_CLR_RESET[3:0];
			err_clr_reg  <= HCS_CLR_RESET;
		end else begin
			temp_clr_reg <= temp_keep | temp_set;
			err_clr_reg  <= err_keep | err_set;
		end
	end

	// Clear commands go straight to the status flags
	assign temp_clear_cmd  = temp_clr_reg;
	assign error_clear_cmd = err_clr_reg;

	// Effective settings; PEC and parity matter only under I3C
	wire       pec_on   = cfg_reg[HCS_CFG_PEC_BIT] & proto_live_reg;
	wire       par_ign  = cfg_reg[HCS_CFG_PAR_BIT] & proto_live_reg;
	wire [1:0] dps      = cfg_reg[HCS_CFG_DPS_HI:HCS_CFG_DPS_LO];
	// Reserved start codes leave the host pointer in charge
	wire       dp_on    = cfg_reg[HCS_CFG_DPE_BIT] & (dps == HCS_DPS_ERR_STATUS);
	wire       long_bl  = cfg_reg[HCS_CFG_BL_BIT] & pec_on & dp_on;

	// Settings registered so the consumer sees glitch-free values
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			cfg <= '0;
		end else begin
			cfg.proto_i3c            <= proto_live_reg;
			cfg.packet_check_on      <= pec_on;
			cfg.parity_ignore        <= par_ign;
			cfg.default_pointer_on   <= dp_on;
			cfg.default_pointer_addr <= dp_on ? HCS_ADDR_ERR_STATUS : 8'h00;
			cfg.burst_bytes          <= long_bl ? HCS_BURST_LONG : HCS_BURST_SHORT;
		end
	end

	// Clear registers are write-only and read back as zero
	wire [7:0] rd_mux = hit_cfg ? cfg_reg : 8'h00;

	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			rd_data <= 8'h00;
		end else if (req.rd_en) begin
			rd_data <= rd_mux;
		end
	end

endmodule : hcs_config_clear

// ===== hcs_config_clear_properties.sv
module hcs_config_clear_chk
	import hcs_pkg::*;
(
	input wire logic       mclk,
	input wire logic       rst_b,
	input wire hcs_req_t   req,
	input wire hcs_evt_t   evt,
	input wire logic [3:0] temp_status_flags,
	input wire logic [7:0] rd_data,
	input wire logic [3:0] temp_clear_cmd,
	input wire logic [7:0] error_clear_cmd,
	input wire hcs_cfg_t   cfg
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_b);
	// Decoded host accesses
	wire wt = req.wr_en && req.addr == HCS_ADDR_TEMP_CLR;
	wire we = req.wr_en && req.addr == HCS_ADDR_ERR_CLR;
	wire wc = req.wr_en && req.addr == HCS_ADDR_DEV_CFG;
	wire rc = req.rd_en && (req.addr == HCS_ADDR_TEMP_CLR || req.addr == HCS_ADDR_ERR_CLR);
	a_temp_clr_set: assert property (
		wt |=> (temp_clear_cmd & $past(req.wdata[3:0])) == $past(req.wdata[3:0])) else $error("temp clear missed");
	a_err_clr_set: assert property (
		we |=> (error_clear_cmd & $past(req.wdata) & HCS_ERR_MASK) == ($past(req.wdata) & HCS_ERR_MASK))
		else $error("error clear missed");
	a_err_reserved: assert property (
		(error_clear_cmd & ~HCS_ERR_MASK) == 8'h00) else $error("reserved clear bit set");
	a_temp_self_clr: assert property (
		temp_clear_cmd[0] && !temp_status_flags[0] && !wt |=> !temp_clear_cmd[0]) else $error("no self clear");
	a_proto_no_wr: assert property (
		wc |=> $stable(cfg.proto_i3c)) else $error("protocol changed by write");
	a_reset_evt: assert property (
		evt.rstdaa || evt.bus_reset |-> ##[1:3] !cfg.packet_check_on && !cfg.parity_ignore)
		else $error("check bits kept after reset event");
	a_clr_rd_zero: assert property (
		rc |=> rd_data == 8'h00) else $error("clear register read not zero");
	a_dp_target: assert property (
		cfg.default_pointer_on |-> cfg.default_pointer_addr == HCS_ADDR_ERR_STATUS) else $error("bad pointer");
endmodule : hcs_config_clear_chk

bind hcs_config_clear hcs_config_clear_chk i_chk (.mclk(mclk), .rst_b(rst_b), .req(req), .evt(evt),
	.temp_status_flags(temp_status_flags), .rd_data(rd_data), .temp_clear_cmd(temp_clear_cmd),
	.error_clear_cmd(error_clear_cmd), .cfg(cfg));

// ===== hcs_host_model.sv
module hcs_host_model (
	output logic scl,
	output logic sda
);
	timeunit 1ns;
	timeprecision 1ns;
	// Pulled-up idle bus; the link clock stands still between frames
	initial begin
		scl = 1'b1;
		sda = 1'b1;
	end
	// START, two 125 ns link clocks, then STOP so staged settings apply
	task automatic frame();
		#63 sda = 1'b0;
		repeat (2) begin // Data held low: a fixed T bit level
			#62 scl = 1'b0;
			#63 scl = 1'b1;
		end
		#62 sda = 1'b1;
		#63;
	endtask : frame
endmodule : hcs_host_model

// ===== tb.sv
module tb;
	import hcs_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic       mclk = 1'b0;
	logic       rst_b = 1'b0;
	hcs_req_t   req = '0;
	hcs_evt_t   evt = '0;
	logic       set_pc = 1'b0;
	logic       set_pd = 1'b0;
	logic [3:0] tflags = 4'hf;
	logic [7:0] eflags = 8'hff;
	logic [7:0] rd_data;
	logic [3:0] tcc;
	logic [7:0] ecc;
	hcs_cfg_t   cfg;
	logic       scl;
	logic       sda;
	int         n_errors = 0;
	int         n_tests = 0;
	// 100 MHz clock
	always #5 mclk = ~mclk;
	hcs_host_model i_hcs_host_model (.scl(scl), .sda(sda));
	hcs_config_clear i_hcs_config_clear (.mclk(mclk), .rst_b(rst_b), .scl_pin(scl), .sda_pin(sda),
		.req(req), .evt(evt), .set_packet_check(set_pc), .set_parity_disable(set_pd),
		.temp_status_flags(tflags), .error_log_flags(eflags), .rd_data(rd_data),
		.temp_clear_cmd(tcc), .error_clear_cmd(ecc), .cfg(cfg));
	task automatic chk(logic [7:0] seen, logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_errors++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	// One-cycle strobe; results are looked at on the falling edge after
	task automatic acc(logic wr, logic [7:0] a, logic [7:0] d);
		@(posedge mclk) req <= '{wr, !wr, a, d};
		@(posedge mclk) req <= '0;
		@(negedge mclk);
	endtask : acc
	task automatic pulse(hcs_evt_t e, logic pc, logic pd);
		@(posedge mclk) {evt, set_pc, set_pd} <= {e, pc, pd};
		@(posedge mclk) {evt, set_pc, set_pd} <= '0;
	endtask : pulse
	task automatic close_out();
		$display("comparisons %0d mismatches %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : close_out
	// Watchdog well beyond the roughly two hundred cycles the sequence needs
	initial begin
		#100000;
		n_errors++;
		close_out();
	end
	initial begin
		repeat (4) @(posedge mclk);
		rst_b <= 1'b1;
		acc(0, HCS_ADDR_DEV_CFG, 8'h00);
		chk(rd_data, HCS_CFG_RESET);
		acc(1, HCS_ADDR_DEV_CFG, 8'hff);
		acc(0, HCS_ADDR_DEV_CFG, 8'h00);
		chk(rd_data, 8'h00);
		i_hcs_host_model.frame();
		acc(0, HCS_ADDR_DEV_CFG, 8'h00);
		chk(rd_data, 8'h1e);
		chk(cfg.default_pointer_on, 8'h00);
		acc(1, HCS_ADDR_DEV_CFG, 8'h12);
		pulse('{1'b1, 1'b0, 1'b0}, 1'b1, 1'b1);
		i_hcs_host_model.frame();
		chk(cfg.proto_i3c, 8'h00);
		chk(cfg.packet_check_on, 8'h00);
		i_hcs_host_model.frame();
		acc(0, HCS_ADDR_DEV_CFG, 8'h00);
		chk(rd_data, 8'hf2);
		chk(cfg.proto_i3c, 8'h01);
		chk(cfg.parity_ignore, 8'h01);
		chk(cfg.packet_check_on, 8'h01);
		chk(cfg.default_pointer_on, 8'h01);
		chk(cfg.default_pointer_addr, HCS_ADDR_ERR_STATUS);
		chk(cfg.burst_bytes, HCS_BURST_LONG);
		// RSTDAA first, then bus reset, each from a set state
		for (int i = 0; i < 2; i++) begin
			pulse('{1'b0, i == 0, i == 1}, 1'b0, 1'b0);
			acc(0, HCS_ADDR_DEV_CFG, 8'h00);
			chk(rd_data, 8'h12);
			pulse('{1'b1, 1'b0, 1'b0}, 1'b1, 1'b1);
		end
		acc(1, HCS_ADDR_TEMP_CLR, 8'hf5);
		chk(tcc, 8'h05);
		acc(1, HCS_ADDR_ERR_CLR, 8'hff);
		chk(ecc, 8'he3);
		acc(1, HCS_ADDR_ERR_CLR, 8'h00);
		chk(ecc, 8'he3);
		acc(0, HCS_ADDR_ERR_CLR, 8'h00);
		chk(rd_data, 8'h00);
		acc(0, 8'h77, 8'h00);
		chk(rd_data, 8'h00);
		chk(tcc, 8'h05);
		@(posedge mclk) {tflags, eflags} <= 12'h000;
		repeat (4) @(posedge mclk);
		chk({tcc, ecc[3:0]}, 8'h00);
		chk(ecc, 8'h00);
		close_out();
	end
endmodule : tb
